/* verilog/store_exec_pkg.sv */
package store_exec_pkg;

   // Instruction field positions (bit 0 of the word is the MSB, so LSB-relative here)
   localparam int unsigned OPCD_MSB      = 31;
   localparam int unsigned OPCD_LSB      = 26;
   localparam int unsigned RS_MSB        = 25;
   localparam int unsigned RS_LSB        = 21;
   localparam int unsigned RA_MSB        = 20;
   localparam int unsigned RA_LSB        = 16;
   localparam int unsigned RB_MSB        = 15;
   localparam int unsigned RB_LSB        = 11;
   localparam int unsigned XO_MSB        = 10;
   localparam int unsigned XO_LSB        = 1;
   localparam int unsigned RSV_BIT       = 0;

   // Primary and extended opcodes
   localparam logic [5:0] OP_BYTE_UPD    = 6'd39;
   localparam logic [5:0] OP_HALF        = 6'd44;
   localparam logic [5:0] OP_HALF_UPD    = 6'd45;
   localparam logic [5:0] OP_EXT         = 6'd31;
   localparam logic [9:0] XO_BYTE_UPD_X  = 10'd247;
   localparam logic [9:0] XO_BYTE_X      = 10'd215;
   localparam logic [9:0] XO_HALF_REV_X  = 10'd918;
   localparam logic [9:0] XO_HALF_UPD_X  = 10'd439;
   localparam logic [9:0] XO_HALF_X      = 10'd407;

   // Protection zone codes presented by the MMU for the hit entry
   localparam logic [1:0] ZONE_NO_ACCESS = 2'b00;
   localparam logic [1:0] ZONE_READ_ONLY = 2'b01;
   localparam logic [1:0] ZONE_WRITABLE  = 2'b10;

   // Value of outputs after reset
   localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

   // Decoded store operation
   typedef struct packed {
      logic       valid;
      logic       half;       // 1: halfword, 0: byte
      logic       update;     // Base written back
      logic       indexed;    // Index register instead of displacement
      logic       reversed;   // Byte-reversed halfword
      logic       invalid;    // Invalid form (boundedly undefined)
   } store_op_t;

   // Register-file read answer
   typedef struct packed {
      logic [31:0] source;
      logic [31:0] base;
      logic [31:0] index;
   } gpr_read_t;

   // Memory write request
   typedef struct packed {
      logic [31:0] address;
      logic [15:0] data;      // data[15:8] goes to address, data[7:0] to address+1
      logic        half;
   } mem_write_t;

   // Translation/protection answer for the current address
   typedef struct packed {
      logic       tlb_hit;
      logic [1:0] zone;
   } xlate_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_XLATE = 2'b01,
      ST_DONE  = 2'b11
   } exec_state_t;

endpackage

/* verilog/byte_halfword_store_exec.sv */
// Overview of operation
// - Displacement forms sign-extend the 16-bit immediate to 32 bits.
// - Non-update forms use zero base when base field is zero.
// - Update forms always read the named base register.
// - Indexed forms add full index register contents to the base.
// - Byte stores write source bits 24..31 to the addressed byte.
// - Halfword stores write source bits 16..31 to the addressed halfword.
// - Update forms write the address back to base; others change nothing.
// - Reversed halfword puts bits 24..31 at address, 16..23 at address+1.
// - Update form with base field zero is invalid, no program exception.
// - Indexed forms with reserved bit set are invalid, no program exception.
// - Relocated store forbidden by zone raises data-storage exception, no write.
// - No-access zone blocks stores only in user mode.
// - Read-only zone blocks stores in user and privileged modes.
// - Relocated store without matching translation raises data TLB miss.
// - Primary opcodes 39, 44 and 45 are decoded.
// - Extended opcodes 247 and 215 under 31 are byte update-indexed and indexed.
// - Extended opcode 918 under 31 is reversed halfword indexed.
// - Extended opcode 439 under 31 is halfword update indexed.
// - Extended opcode 407 under 31 is halfword indexed, zero base allowed.
`timescale 1ns/1ns
`default_nettype none
module byte_halfword_store_exec
   import store_exec_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        issue_valid_i,
   input  wire logic [31:0] instr_i,
   input  wire logic        user_mode_i,
   input  wire logic        relocate_i,
   input  wire gpr_read_t   gpr_i,
   input  wire xlate_t      xlate_i,
   input  wire logic        mem_ready_i,
   output logic             issue_ready_o,
   output logic [4:0]       source_gpr_o,
   output logic [4:0]       base_gpr_o,
   output logic [4:0]       index_gpr_o,
   output logic             xlate_req_o,
   output logic [31:0]      effective_address_o,
   output logic             mem_valid_o,
   output mem_write_t       mem_o,
   output logic             wb_valid_o,
   output logic [4:0]       wb_gpr_o,
   output logic [31:0]      wb_data_o,
   output logic             dsi_o,
   output logic             dtlb_miss_o,
   output logic             invalid_form_o,
   output logic             done_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Shared by the issue check and the latched operation
   function automatic store_op_t decode(input logic [31:0] ins);
      store_op_t op;
      op = '0;
      case (ins[OPCD_MSB:OPCD_LSB])
         OP_BYTE_UPD: op = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
         OP_HALF:     op = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
         OP_HALF_UPD: op = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
         OP_EXT:
         begin
            case (ins[XO_MSB:XO_LSB])
               XO_BYTE_UPD_X: op = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
               XO_BYTE_X:     op = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
               XO_HALF_REV_X: op = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
               XO_HALF_UPD_X: op = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
               XO_HALF_X:     op = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
               default:       op = '0;
            endcase
            // Reserved bit set: still executed, only flagged
            op.invalid = op.valid & ins[RSV_BIT];
         end
         default: op = '0;
      endcase
      // Update with base field zero: executed as written, flagged only
      if (op.update && (ins[RA_MSB:RA_LSB] == 5'd0))
      begin
         op.invalid = 1'b1;
      end
      return op;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   exec_state_t state_r;
   store_op_t   op_r;
   logic [31:0] instr_r;
   logic [31:0] ea_nxt;
   logic [31:0] base_val;
   logic [31:0] offset_val;
   logic        blocked;
   logic        accept;
   store_op_t   dec_in;

   // Decoded once into a net; a member select on a call result is not taken everywhere
   assign dec_in        = decode(instr_i);
   assign accept        = issue_valid_i && (state_r == ST_IDLE) && dec_in.valid;
   assign issue_ready_o = (state_r == ST_IDLE);

   // Register file addresses come from the latched instruction
   assign source_gpr_o = instr_r[RS_MSB:RS_LSB];
   assign base_gpr_o   = instr_r[RA_MSB:RA_LSB];
   assign index_gpr_o  = instr_r[RB_MSB:RB_LSB];

   // Base and offset selection
   always_comb
   begin
      if (!op_r.update && (instr_r[RA_MSB:RA_LSB] == 5'd0))
      begin
         base_val = 32'h0000_0000;
      end
      else
      begin
         base_val = gpr_i.base;
      end
      if (op_r.indexed)
      begin
         offset_val = gpr_i.index;
      end
      else
      begin
         offset_val = {{16{instr_r[15]}}, instr_r[15:0]};
      end
      ea_nxt = base_val + offset_val;
   end

   // Protection check; without relocation nothing is checked
   always_comb
   begin
      blocked = 1'b0;
      if (xlate_i.zone == ZONE_READ_ONLY)
      begin
         blocked = 1'b1;
      end
      else if ((xlate_i.zone == ZONE_NO_ACCESS) && user_mode_i)
      begin
         blocked = 1'b1;
      end
   end

   // Sequencer: idle, wait for translation and memory, answer
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (accept)
               begin
                  state_r <= ST_XLATE;
               end
            end
            ST_XLATE:
            begin
               // Faults finish at once; a write waits for memory
               if (relocate_i && (!xlate_i.tlb_hit || blocked))
               begin
                  state_r <= ST_DONE;
               end
               else if (mem_ready_i)
               begin
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Instruction capture
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         instr_r <= 32'h0000_0000;
         op_r    <= '0;
      end
      else if (accept)
      begin
         instr_r <= instr_i;
         op_r    <= dec_in;
      end
   end

   // Address toward the MMU is held while translating
   assign xlate_req_o         = (state_r == ST_XLATE);
   assign effective_address_o = ea_nxt;

   // Memory request and data lanes
   always_comb
   begin
      mem_valid_o    = (state_r == ST_XLATE)
                       && !(relocate_i && (!xlate_i.tlb_hit || blocked));
      mem_o.address  = ea_nxt;
      mem_o.half     = op_r.half;
      if (!op_r.half)
      begin
         mem_o.data = {gpr_i.source[7:0], 8'h00};
      end
      else if (op_r.reversed)
      begin
         mem_o.data = {gpr_i.source[7:0], gpr_i.source[15:8]};
      end
      else
      begin
         mem_o.data = gpr_i.source[15:0];
      end
   end

   // Outcome registers, pulsed in ST_DONE
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wb_valid_o     <= 1'b0;
         wb_gpr_o       <= 5'd0;
         wb_data_o      <= ADDR_RESET;
         dsi_o          <= 1'b0;
         dtlb_miss_o    <= 1'b0;
         invalid_form_o <= 1'b0;
         done_o         <= 1'b0;
      end
      else
      begin
         wb_valid_o     <= 1'b0;
         dsi_o          <= 1'b0;
         dtlb_miss_o    <= 1'b0;
         invalid_form_o <= 1'b0;
         done_o         <= 1'b0;
         if ((state_r == ST_XLATE) && (mem_valid_o ? mem_ready_i : 1'b1))
         begin
            done_o         <= 1'b1;
            invalid_form_o <= op_r.invalid;
            dtlb_miss_o    <= relocate_i && !xlate_i.tlb_hit;
            dsi_o          <= relocate_i && xlate_i.tlb_hit && blocked;
            // Write-back only when the store went out
            wb_valid_o     <= op_r.update && mem_valid_o;
            wb_gpr_o       <= instr_r[RA_MSB:RA_LSB];
            wb_data_o      <= ea_nxt;
         end
      end
   end

endmodule
`default_nettype wire

/* dv/mem_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mem_side_model
   import store_exec_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic [4:0]  src_i,
   input  wire logic [4:0]  bas_i,
   input  wire logic [4:0]  idx_i,
   input  wire logic [31:0] gpr_file_i [32],
   input  wire logic        xlate_req_i,
   input  wire xlate_t      cfg_i,
   input  wire logic [1:0]  stall_i,
   output gpr_read_t        gpr_o,
   output xlate_t           xlate_o,
   output logic             mem_ready_o
);
   logic [1:0] wait_r;
   // Register file answers in the same cycle
   assign gpr_o = {gpr_file_i[src_i], gpr_file_i[bas_i], gpr_file_i[idx_i]};
   // Inverted outside translation so a stale answer never helps
   assign xlate_o = xlate_req_i ? cfg_i : ~cfg_i;
   assign mem_ready_o = wait_r >= stall_i;
   // Holds acceptance off for stall_i cycles of each translation
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wait_r <= 2'h0;
      end
      else if (!xlate_req_i)
      begin
         wait_r <= 2'h0;
      end
      else if (!mem_ready_o)
      begin
         wait_r <= wait_r + 2'h1;
      end
   end
endmodule
`default_nettype wire

/* dv/store_exec_props.sv */
`timescale 1ns/1ns
`default_nettype none
module store_exec_props
   import store_exec_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        user_mode_i,
   input wire logic        relocate_i,
   input wire xlate_t      xlate_i,
   input wire logic        mem_ready_i,
   input wire logic        issue_ready_o,
   input wire logic        xlate_req_o,
   input wire logic [31:0] effective_address_o,
   input wire logic        mem_valid_o,
   input wire mem_write_t  mem_o,
   input wire logic        wb_valid_o,
   input wire logic [31:0] wb_data_o,
   input wire logic        dsi_o,
   input wire logic        dtlb_miss_o,
   input wire logic        done_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic hit;
   logic bad;
   // A forbidden relocated store; tlb miss wins over zone
   assign hit = xlate_req_o && relocate_i && xlate_i.tlb_hit;
   assign bad = hit && (xlate_i.zone == ZONE_READ_ONLY || xlate_i.zone == ZONE_NO_ACCESS && user_mode_i);
   sequence s_put; mem_valid_o && mem_ready_i; endsequence
   sequence s_miss; xlate_req_o && relocate_i && !xlate_i.tlb_hit; endsequence
   sequence s_priv; hit && xlate_i.zone == ZONE_NO_ACCESS && !user_mode_i && mem_ready_i; endsequence
   tlb_miss_a: assert property (s_miss |=> dtlb_miss_o && !dsi_o) else $error("miss lost");
   zone_block_a: assert property (bad |=> dsi_o && !wb_valid_o) else $error("zone fault lost");
   priv_pass_a: assert property (s_priv |=> !dsi_o) else $error("privileged store blocked");
   no_put_a: assert property (s_put |-> !bad && !(relocate_i && !xlate_i.tlb_hit)) else $error("faulted write");
   put_done_a: assert property (s_put |=> done_o) else $error("no done after write");
   wb_addr_a: assert property (wb_valid_o |-> done_o && wb_data_o == $past(effective_address_o))
      else $error("wb");
   fault_wb_a: assert property (dsi_o || dtlb_miss_o |-> !wb_valid_o) else $error("wb after fault");
   put_addr_a: assert property (mem_valid_o |-> xlate_req_o && mem_o.address == effective_address_o)
      else $error("addr");
   // A write that memory holds off must stand unchanged until taken
   put_hold_a: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_o))
      else $error("request dropped");
   busy_a: assert property (xlate_req_o |-> !issue_ready_o) else $error("ready while busy");
endmodule
bind byte_halfword_store_exec store_exec_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .user_mode_i(user_mode_i), .relocate_i(relocate_i), .xlate_i(xlate_i), .mem_ready_i(mem_ready_i),
   .issue_ready_o(issue_ready_o), .xlate_req_o(xlate_req_o), .effective_address_o(effective_address_o),
   .mem_valid_o(mem_valid_o), .mem_o(mem_o), .wb_valid_o(wb_valid_o), .wb_data_o(wb_data_o),
   .dsi_o(dsi_o), .dtlb_miss_o(dtlb_miss_o), .done_o(done_o));
`default_nettype wire

/* dv/byte_halfword_store_exec_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module byte_halfword_store_exec_tb
   import store_exec_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        iv = 1'b0;
   logic        user = 1'b0;
   logic        reloc = 1'b0;
   logic [31:0] instr = 32'h0000_0000;
   logic [31:0] rnd = 32'h0000_005D;
   logic [1:0]  stall = 2'h0;
   xlate_t      cfg = 3'h0;
   logic [31:0] gpr [32];
   logic [5:0]  po [8] = '{OP_BYTE_UPD, OP_HALF, OP_HALF_UPD, OP_EXT, OP_EXT, OP_EXT, OP_EXT, OP_EXT};
   logic [9:0]  xo [8] = '{10'h000, 10'h000, 10'h000, XO_BYTE_UPD_X, XO_BYTE_X, XO_HALF_REV_X, XO_HALF_UPD_X,
                           XO_HALF_X};
   gpr_read_t   gpr_rd;
   xlate_t      xl;
   mem_write_t  mem;
   logic        rdy, irdy, xreq, mv, wbv, dsi, miss, inv, done;
   logic [4:0]  src, bas, idx, wbg;
   logic [31:0] ea, wbd, w;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #4 clock = ~clock;
   byte_halfword_store_exec dut (.clock_i(clock), .rst_n_i(rst_n), .issue_valid_i(iv), .instr_i(instr),
      .user_mode_i(user), .relocate_i(reloc), .gpr_i(gpr_rd), .xlate_i(xl), .mem_ready_i(rdy),
      .issue_ready_o(irdy), .source_gpr_o(src), .base_gpr_o(bas), .index_gpr_o(idx), .xlate_req_o(xreq),
      .effective_address_o(ea), .mem_valid_o(mv), .mem_o(mem), .wb_valid_o(wbv), .wb_gpr_o(wbg),
      .wb_data_o(wbd), .dsi_o(dsi), .dtlb_miss_o(miss), .invalid_form_o(inv), .done_o(done));
   mem_side_model far (.clock_i(clock), .rst_n_i(rst_n), .src_i(src), .bas_i(bas), .idx_i(idx),
      .gpr_file_i(gpr), .xlate_req_i(xreq), .cfg_i(cfg), .stall_i(stall), .gpr_o(gpr_rd), .xlate_o(xl),
      .mem_ready_o(rdy));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One store: the model predicts address, data, write-back and faults
   task automatic run(input logic [31:0] w);
      logic        h, u, x, r, f, put;
      logic [31:0] e, s;
      x = w[31:26] == OP_EXT;
      r = x && w[10:1] == XO_HALF_REV_X;
      h = x ? w[10:1] != XO_BYTE_X && w[10:1] != XO_BYTE_UPD_X : w[31:26] != OP_BYTE_UPD;
      u = x ? w[10:1] == XO_BYTE_UPD_X || w[10:1] == XO_HALF_UPD_X : w[31:26] != OP_HALF;
      e = (u || w[20:16] != 5'h00) ? gpr[w[20:16]] : 32'h0000_0000;
      e = e + (x ? gpr[w[15:11]] : {{16{w[15]}}, w[15:0]});
      s = gpr[w[25:21]];
      f = reloc && (!cfg.tlb_hit || cfg.zone == ZONE_READ_ONLY || cfg.zone == ZONE_NO_ACCESS && user);
      put = 1'b0;
      @(posedge clock);
      #1 iv = 1'b1;
      instr = w;
      @(posedge clock);
      #1 iv = 1'b0;
      for (int k = 0; k < 12 && done !== 1'b1; k++)
      begin
         @(negedge clock);
         if (mv === 1'b1 && rdy === 1'b1)
         begin
            put = 1'b1;
            cmp32(mem.address, e);
            cmp1(mem.half, h);
            cmp32({16'h0000, mem.data[15:8], h ? mem.data[7:0] : 8'h00},
               {16'h0000, r ? {s[7:0], s[15:8]} : h ? s[15:0] : {s[7:0], 8'h00}});
         end
      end
      cmp1(done, 1'b1);
      cmp1(put, !f);
      cmp1(dsi, f && cfg.tlb_hit);
      cmp1(miss, reloc && !cfg.tlb_hit);
      cmp1(inv, u && w[20:16] == 5'h00 || x && w[0]);
      cmp1(wbv, u && !f);
      if (u && !f)
      begin
         cmp32({27'h000_0000, wbg}, {27'h000_0000, w[20:16]});
         cmp32(wbd, e);
         gpr[w[20:16]] = e;
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Every store form meets every protection case
   initial
   begin
      for (int i = 0; i < 32; i++)
      begin
         gpr[i] = rnd;
         rnd = lfsr(rnd);
      end
      repeat (5) @(posedge clock);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 48; i++)
      begin
         // Inputs only move just after a rising edge
         @(posedge clock);
         #1;
         if (i == 24)
         begin
            rst_n = 1'b0;
            #1;
            cmp1(wbv | dsi | miss | done | xreq, 1'b0);
            @(posedge clock);
            #1 rst_n = 1'b1;
            cmp1(irdy, 1'b1);
         end
         rnd = lfsr(rnd);
         w = rnd;
         w[31:26] = po[i % 8];
         if (i % 8 > 2)
            w[10:0] = {xo[i % 8], rnd[7] & rnd[3]};
         if (i / 8 == 0 || i / 8 == 4)
            w[20:16] = 5'h00;
         reloc = i / 8 != 0;
         cfg = {i / 8 != 1, i / 8 == 4 ? ZONE_READ_ONLY : i / 8 == 5 ? ZONE_WRITABLE : ZONE_NO_ACCESS};
         user = i / 8 == 2 || i / 8 > 3 && rnd[5];
         stall = i / 8 == 5 ? 2'h2 : {1'b0, i / 8 == 0};
         run(w);
      end
      // A non-store word is ignored
      @(posedge clock);
      #1 iv = 1'b1;
      instr = 32'h9000_0000;
      repeat (2) @(negedge clock);
      cmp1(xreq, 1'b0);
      cmp1(irdy, 1'b1);
      close_out();
   end
   // Hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         fail_count++;
         $display("MISMATCH %0t timeout", $time);
         close_out();
      end
   end
endmodule
`default_nettype wire
